// File: pkg/nsled_pkg.sv
// constants and types for the network status indicator driver
//
// Contract
// - each of the three indicator outputs has two display modes and the mode picks what it shows.
// - in the first mode the link/activity output is steadily on while a good link is detected.
// - in either mode the activity output blinks at 10 Hz while receive or transmit activity is seen.
// - in the first mode the speed output is on at 100 Mb/s and off at 10 Mb/s.
// - in the second mode the speed output is a 100 Mb/s link lamp, on while 100 Mb/s operation is seen.
// - in the first mode the duplex/collision output is steadily on while full duplex is detected.
// - in the first mode at half duplex the duplex/collision output blinks at 20 Hz during collisions.
// - in the second mode the duplex/collision output is a 10 Mb/s link lamp, on during 10 Mb/s operation.
// - blink timing is counted from the 25 MHz physical-layer reference clock input.
// - an asserted auxiliary-power sense input means the system offers auxiliary power.
// - an asserted main-power sense input means bus-supplied main power is available.
package nsled_pkg;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int REF_CLOCK_HZ    = 25_000_000;
  localparam int SLOW_BLINK_HZ   = 10;
  localparam int FAST_BLINK_HZ   = 20;
  localparam int SLOW_HALF_TICKS = REF_CLOCK_HZ / (2 * SLOW_BLINK_HZ);
  localparam int FAST_HALF_TICKS = REF_CLOCK_HZ / (2 * FAST_BLINK_HZ);
  localparam int BLINK_CNT_W     = 21;
  localparam int NUM_BLINKERS    = 2;
  localparam int SLOW_BLINKER    = 0;
  localparam int FAST_BLINKER    = 1;
  localparam int SYNC_STAGES     = 2;
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;

  // ------------------------------------------------------------------
  // register port
  // ------------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [3:0]  CTRL_ADDR   = 4'h0;
  localparam logic [3:0]  STATUS_ADDR = 4'h4;
  localparam logic [31:0] CTRL_RESET  = 32'h0;
  localparam int CTRL_MODE_BIT = 0;

  // status word layout: sensed inputs, then lamps, then mode
  localparam int NUM_SENSE   = 8;
  localparam int SNS_LINK    = 0;
  localparam int SNS_RX      = 1;
  localparam int SNS_TX      = 2;
  localparam int SNS_SPEED   = 3;
  localparam int SNS_DUPLEX  = 4;
  localparam int SNS_COL     = 5;
  localparam int SNS_AUX     = 6;
  localparam int SNS_MAIN    = 7;
  localparam int ST_LAMP_LSB = 8;
  localparam int ST_MODE_BIT = 11;
  localparam int ST_KNOWN    = 12;

  typedef enum logic {
    NSLED_MODE_FIRST  = 1'b0,
    NSLED_MODE_SECOND = 1'b1
  } nsled_mode_t;

endpackage

// File: rtl/nsled_top.sv
// network status indicator driver: lamps, blink timing, power sense
`timescale 1ns/1ns
module nsled_top
  import nsled_pkg::*;
#(
  parameter int SLOW_HALF = SLOW_HALF_TICKS,
  parameter int FAST_HALF = FAST_HALF_TICKS
) (
  input  wire logic              clock,                      // 100 MHz
  input  wire logic              rst,                        // sync, high
  input  wire logic [ADDR_W-1:0] addr,                       // reg address
  input  wire logic [DATA_W-1:0] wdata,                      // write data
  input  wire logic              wr_en,                      // write strobe
  input  wire logic              rd_en,                      // read strobe
  output logic      [DATA_W-1:0] rdata,                      // read data
  input  wire logic              ref_clock_in,               // 25 MHz ref
  output logic                   ref_clock_out,              // crystal return
  input  wire logic              link_good,                  // link test ok
  input  wire logic              rx_active,                  // valid receive
  input  wire logic              tx_active,                  // valid transmit
  input  wire logic              speed_100,                  // 1 = 100 Mb/s
  input  wire logic              full_duplex,                // 1 = full duplex
  input  wire logic              collision,                  // collision seen
  input  wire logic              aux_power_sense,            // aux power pin
  input  wire logic              main_power_sense,           // main power pin
  output logic                   link_activity_indicator,    // lamp 0
  output logic                   speed_indicator,            // lamp 1
  output logic                   duplex_collision_indicator, // lamp 2
  output logic                   aux_power_present,          // aux available
  output logic                   main_power_present,         // main available
  output logic                   display_mode                // 1 = second
);

  // ------------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------------
  logic [NUM_SENSE-1:0] sense_raw;
  logic [NUM_SENSE-1:0] sense_s1_q;
  logic [NUM_SENSE-1:0] sense_q;

  assign sense_raw[SNS_LINK]   = link_good;
  assign sense_raw[SNS_RX]     = rx_active;
  assign sense_raw[SNS_TX]     = tx_active;
  assign sense_raw[SNS_SPEED]  = speed_100;
  assign sense_raw[SNS_DUPLEX] = full_duplex;
  assign sense_raw[SNS_COL]    = collision;
  assign sense_raw[SNS_AUX]    = aux_power_sense;
  assign sense_raw[SNS_MAIN]   = main_power_sense;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SENSE; gi++) begin : g_sync
      always_ff @(posedge clock) begin
        if (rst) begin
          sense_s1_q[gi] <= 1'b0;
          sense_q[gi]    <= 1'b0;
        end else begin
          sense_s1_q[gi] <= sense_raw[gi];
          sense_q[gi]    <= sense_s1_q[gi];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // reference clock sampling and tick
  // ------------------------------------------------------------------
  logic ref_s1_q;
  logic ref_s2_q;
  logic ref_s3_q;
  logic ref_out_q;
  wire  ref_tick = ref_s2_q & ~ref_s3_q;  // one pulse per ref period

  always_ff @(posedge clock) begin
    if (rst) begin
      ref_s1_q  <= 1'b0;
      ref_s2_q  <= 1'b0;
      ref_s3_q  <= 1'b0;
      ref_out_q <= 1'b1;
    end else begin
      ref_s1_q  <= ref_clock_in;
      ref_s2_q  <= ref_s1_q;
      ref_s3_q  <= ref_s2_q;
      ref_out_q <= ~ref_s2_q;
    end
  end

  assign ref_clock_out = ref_out_q;

  // ------------------------------------------------------------------
  // status-known settle counter
  // ------------------------------------------------------------------
  logic [1:0] settle_q;
  wire        known = (settle_q == SETTLE_CYCLES);

  always_ff @(posedge clock) begin
    if (rst) begin
      settle_q <= 2'h0;
    end else if (!known) begin
      settle_q <= settle_q + 2'h1;  // lamps stay dark until inputs settle
    end
  end

  // ------------------------------------------------------------------
  // control register
  // ------------------------------------------------------------------
  nsled_mode_t mode_q;
  wire         ctrl_hit   = (addr == CTRL_ADDR);
  wire         status_hit = (addr == STATUS_ADDR);

  always_ff @(posedge clock) begin
    if (rst) begin
      mode_q <= nsled_mode_t'(CTRL_RESET[CTRL_MODE_BIT]);  // first mode
    end else if (wr_en && ctrl_hit) begin
      mode_q <= nsled_mode_t'(wdata[CTRL_MODE_BIT]);
    end
  end

  // ------------------------------------------------------------------
  // blink generators: slow for activity, fast for collisions
  // ------------------------------------------------------------------
  wire activity = sense_q[SNS_RX] | sense_q[SNS_TX];
  wire half_col = sense_q[SNS_COL] & ~sense_q[SNS_DUPLEX];

  logic [NUM_BLINKERS-1:0] blink_trig;
  logic [NUM_BLINKERS-1:0] blink_phase_q;
  logic [BLINK_CNT_W-1:0]  blink_lim [NUM_BLINKERS];

  assign blink_trig[SLOW_BLINKER] = activity;
  assign blink_trig[FAST_BLINKER] = half_col;
  assign blink_lim[SLOW_BLINKER]  = BLINK_CNT_W'(SLOW_HALF - 1);
  assign blink_lim[FAST_BLINKER]  = BLINK_CNT_W'(FAST_HALF - 1);

  generate
    for (gi = 0; gi < NUM_BLINKERS; gi++) begin : g_blink
      logic [BLINK_CNT_W-1:0] cnt_q;
      wire                    wrap = (cnt_q == blink_lim[gi]);

      always_ff @(posedge clock) begin
        if (rst || !blink_trig[gi]) begin
          // restart lit so a blink begins with an on half
          cnt_q            <= '0;
          blink_phase_q[gi] <= 1'b1;
        end else if (ref_tick) begin
          if (wrap) begin
            cnt_q             <= '0;
            blink_phase_q[gi] <= ~blink_phase_q[gi];  // half duty
          end else begin
            cnt_q <= cnt_q + BLINK_CNT_W'(1);
          end
        end
      end
    end
  endgenerate

  wire slow_blink = blink_phase_q[SLOW_BLINKER];
  wire fast_blink = blink_phase_q[FAST_BLINKER];

  // ------------------------------------------------------------------
  // lamp selection per mode
  // ------------------------------------------------------------------
  wire link   = sense_q[SNS_LINK];
  wire fast   = sense_q[SNS_SPEED];
  wire second = (mode_q == NSLED_MODE_SECOND);

  // first mode: link steady, activity blinks over it
  wire lamp0_first  = activity ? slow_blink : link;
  // second mode: activity only
  wire lamp0_second = activity & slow_blink;
  wire lamp1_first  = fast;
  wire lamp1_second = link & fast;
  wire lamp2_first  = sense_q[SNS_DUPLEX] |
                      (half_col & fast_blink);
  wire lamp2_second = link & ~fast;

  wire lamp0 = second ? lamp0_second : lamp0_first;
  wire lamp1 = second ? lamp1_second : lamp1_first;
  wire lamp2 = second ? lamp2_second : lamp2_first;

  logic lamp0_q;
  logic lamp1_q;
  logic lamp2_q;
  logic aux_q;
  logic main_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      lamp0_q <= 1'b0;
      lamp1_q <= 1'b0;
      lamp2_q <= 1'b0;
      aux_q   <= 1'b0;
      main_q  <= 1'b0;
    end else begin
      lamp0_q <= known & lamp0;
      lamp1_q <= known & lamp1;
      lamp2_q <= known & lamp2;
      aux_q   <= sense_q[SNS_AUX];
      main_q  <= sense_q[SNS_MAIN];
    end
  end

  assign link_activity_indicator    = lamp0_q;
  assign speed_indicator            = lamp1_q;
  assign duplex_collision_indicator = lamp2_q;
  assign aux_power_present          = aux_q;
  assign main_power_present         = main_q;
  assign display_mode               = mode_q;

  // ------------------------------------------------------------------
  // read port
  // ------------------------------------------------------------------
  logic [DATA_W-1:0] ctrl_word;
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] read_word;
  logic [DATA_W-1:0] rdata_q;

  always_comb begin
    ctrl_word                = '0;
    ctrl_word[CTRL_MODE_BIT] = second;
    status_word                             = '0;
    status_word[NUM_SENSE-1:0]              = sense_q;
    status_word[ST_LAMP_LSB +: 3]           = {lamp2_q, lamp1_q, lamp0_q};
    status_word[ST_MODE_BIT]                = second;
    status_word[ST_KNOWN]                   = known;
  end

  assign read_word = ctrl_hit   ? ctrl_word   :
                     status_hit ? status_word : '0;

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rd_en ? read_word : '0;
    end
  end

  assign rdata = rdata_q;

endmodule

// File: tb/nsled_far.sv
// far-side model: reference oscillator and power sense pins
`timescale 1ns/1ns
module nsled_far (
  input  wire logic aux_on,           // system offers aux power
  input  wire logic main_on,          // bus power present
  output logic      ref_clock_in,     // 25 MHz oscillator
  output logic      aux_power_sense,  // aux sense pin
  output logic      main_power_sense  // main sense pin
);
  initial begin
    ref_clock_in = 1'b0;
    #3;
    forever #20 ref_clock_in = ~ref_clock_in;
  end
  assign aux_power_sense  = aux_on;
  assign main_power_sense = main_on;
endmodule

// File: tb/nsled_chk_sva.sv
// assertion checker for the status indicator driver
`timescale 1ns/1ns
module nsled_chk
  import nsled_pkg::*;
#(
  parameter int SLOW_HALF = SLOW_HALF_TICKS,
  parameter int FAST_HALF = FAST_HALF_TICKS
) (
  input wire logic clock,                      // system clock
  input wire logic rst,                        // sync reset
  input wire logic ref_clock_in,               // reference pin
  input wire logic ref_clock_out,              // crystal return
  input wire logic link_good,                  // link status
  input wire logic rx_active,                  // receive seen
  input wire logic tx_active,                  // transmit seen
  input wire logic speed_100,                  // fast speed
  input wire logic full_duplex,                // duplex status
  input wire logic aux_power_sense,            // aux pin
  input wire logic main_power_sense,           // main pin
  input wire logic link_activity_indicator,    // lamp 0
  input wire logic speed_indicator,            // lamp 1
  input wire logic duplex_collision_indicator, // lamp 2
  input wire logic aux_power_present,          // aux out
  input wire logic main_power_present,         // main out
  input wire logic display_mode                // mode out
);
  logic [3:0] run_q;
  wire  [3:0] run_d = (run_q == 4'hf) ? run_q : run_q + 4'h1;
  wire        ready = (run_q == 4'hf);
  always_ff @(posedge clock) begin
    run_q <= rst ? 4'h0 : run_d;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence first_s;
    ready && !display_mode && !$past(display_mode);
  endsequence
  sequence second_s;
    ready && display_mode && $past(display_mode);
  endsequence
  speed_first_a: assert property (
    first_s |-> speed_indicator == $past(speed_100, 3))
    else $error("speed lamp wrong in first mode");
  fast_link_a: assert property (
    second_s |-> speed_indicator == $past(link_good & speed_100, 3))
    else $error("fast link lamp wrong");
  slow_link_a: assert property (
    second_s |-> duplex_collision_indicator
      == $past(link_good & !speed_100, 3))
    else $error("slow link lamp wrong");
  full_duplex_a: assert property (
    first_s ##0 $past(full_duplex, 3) |-> duplex_collision_indicator)
    else $error("duplex lamp not on");
  link_steady_a: assert property (
    first_s ##0 $past(link_good & !rx_active & !tx_active, 3)
      |-> link_activity_indicator)
    else $error("link lamp not steady");
  idle_dark_a: assert property (
    second_s ##0 !$past(rx_active | tx_active, 3)
      |-> !link_activity_indicator)
    else $error("activity lamp lit while idle");
  reset_dark_a: assert property (
    $fell(rst) |-> !(link_activity_indicator | speed_indicator
      | duplex_collision_indicator | display_mode))
    else $error("outputs not cleared by reset");
  aux_sense_a: assert property (
    aux_power_sense [*4] |-> aux_power_present)
    else $error("aux power not reported");
  main_sense_a: assert property (
    !main_power_sense [*4] |-> !main_power_present)
    else $error("main power reported while absent");
  crystal_return_a: assert property (
    ready |-> ref_clock_out == !$past(ref_clock_in, 3))
    else $error("crystal return does not follow reference");
endmodule

bind nsled_top nsled_chk #(.SLOW_HALF(SLOW_HALF), .FAST_HALF(FAST_HALF))
  u_chk (.*);

// File: tb/nsled_top_tb.sv
// self-checking bench for the status indicator driver
`timescale 1ns/1ns
module nsled_top_tb
  import nsled_pkg::*;
;
  localparam int SH = 4;
  localparam int FH = 2;
  logic clock, rst, wr_en, rd_en, rd_v, chk, aux_on, main_on;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic ref_clock_in, ref_clock_out, link_good, rx_active, tx_active;
  logic speed_100, full_duplex, collision, aux_power_sense, main_power_sense;
  logic link_activity_indicator, speed_indicator, duplex_collision_indicator;
  logic aux_power_present, main_power_present, display_mode;
  logic [31:0] rexp[$];
  logic [5:0] lexp[$];
  logic [7:0] p;
  logic [2:0] l;
  int err_total, n_tests, seed;
  wire [5:0] seen = {display_mode, main_power_present, aux_power_present,
    duplex_collision_indicator, speed_indicator, link_activity_indicator};
  nsled_top #(.SLOW_HALF(SH), .FAST_HALF(FH)) uut (.*);
  nsled_far far (.*);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp6(input logic [5:0] got, input logic [5:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input int d);
    @(posedge clock);
    wr_en <= w;
    rd_en <= !w;
    addr  <= a;
    wdata <= d;
    if (!w) rexp.push_back(d);
    @(posedge clock);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask
  task automatic lamps(input logic [5:0] e);
    @(posedge clock);
    chk <= 1'b1;
    lexp.push_back(e);
    @(posedge clock);
    chk <= 1'b0;
  endtask
  task automatic pins(input logic [7:0] v);
    @(posedge clock);
    {main_on, aux_on, collision, full_duplex, speed_100, tx_active,
      rx_active, link_good} <= v;
    repeat (6) @(posedge clock);
  endtask
  // measures one dark span of a blinking lamp in system clocks
  task automatic blink(input int b, input int e);
    int k;
    k = 0;
    while (seen[b] !== 1'b0 && k < 200) begin
      @(posedge clock);
      #1;
      k++;
    end
    k = 0;
    while (seen[b] !== 1'b1 && k < 200) begin
      @(posedge clock);
      #1;
      k++;
    end
    cmp32(k, e);
  endtask
  always @(posedge clock) begin
    rd_v <= rd_en;
    #1;
    if (rd_v) cmp32(rdata, rexp.pop_front());
    if (chk) cmp6(seen, lexp.pop_front());
  end
  initial begin
    #100000;
    err_total++;
    report_and_stop;
  end
  initial begin
    {seed, err_total, n_tests} = {32'h748b, 64'h0};
    {rst, wr_en, rd_en, rd_v, chk, addr, wdata} = {1'b1, 40'h0};
    {main_on, aux_on, collision, full_duplex, speed_100, tx_active,
      rx_active, link_good} = 8'h00;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    lamps(6'h00);
    acc(1'b0, CTRL_ADDR, CTRL_RESET);
    $display("reset test done");
    for (int m = 0; m < 2; m++) begin
      acc(1'b1, CTRL_ADDR, m);
      for (int i = 0; i < 12; i++) begin
        p = $random(seed) & 8'hd9;
        pins(p);
        l = m ? {p[0] & !p[3], p[0] & p[3], 1'b0} : {p[4], p[3], p[0]};
        lamps({m[0], p[7], p[6], l});
        acc(1'b0, STATUS_ADDR, {20'h1, m[0], l, p});
      end
    end
    acc(1'b1, 4'h8, 32'hffffffff);
    acc(1'b0, 4'h8, 32'h0);
    acc(1'b0, CTRL_ADDR, 32'h1);
    $display("steady test done");
    pins(8'h02);
    blink(0, 4 * SH);
    pins(8'h04);
    blink(0, 4 * SH);
    pins(8'h09);
    lamps(6'h22);
    acc(1'b1, CTRL_ADDR, 32'h0);
    pins(8'h21);
    blink(2, 4 * FH);
    pins(8'h03);
    blink(0, 4 * SH);
    pins(8'h01);
    lamps(6'h01);
    $display("blink test done");
    report_and_stop;
  end
endmodule
